// >>> rtl/exec_pkg.sv
// Shared types and constants for the increment / OR / move / branch execution datapath
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int LIT_W = 9;
  localparam int PC_W = 11;
  localparam int FILE_DEPTH = 32;

  // Destination bit encoding
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Field positions inside the branch target and the page bits
  localparam int PC_LOW_MSB = 8;
  localparam int PC_PAGE_LSB = 9;
  localparam int PAGE_W = 2;
  localparam int OR_LIT_MSB = 7;

  // Reset values and data constants
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;

  // Timing counts in instruction cycles
  localparam int BRANCH_CYCLES = 2;
  localparam int SKIP_CYCLES = 2;
  localparam logic [1:0] BRANCH_EXTRA = 2'(BRANCH_CYCLES - 1);
  localparam logic [1:0] SKIP_EXTRA = 2'(SKIP_CYCLES - 1);

  typedef enum logic [2:0] {
    no_operation = 3'b000,
    increment_register_op = 3'b001,
    increment_skip_zero_op = 3'b010,
    unconditional_branch_op = 3'b011,
    or_literal_op = 3'b100,
    or_register_op = 3'b101,
    store_accumulator_op = 3'b110,
    register_move_op = 3'b111
  } op_e;

  typedef enum logic {
    st_exec = 1'b0,
    st_flush = 1'b1
  } state_e;

  typedef struct packed {
    op_e op;
    logic [ADDR_W-1:0] addr;
    logic dest;
    logic [LIT_W-1:0] literal;
  } instr_s;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic result_zero;
    logic wr_acc;
    logic wr_file;
    logic upd_zero;
    logic skip;
    logic branch;
  } alu_out_s;

endpackage : exec_pkg

// >>> rtl/exec_alu.sv
// Combinational operation unit: result, destination and flag decisions
`timescale 1ns/100ps
`default_nettype none
module exec_alu (
  input wire exec_pkg::instr_s instr,
  input wire logic [exec_pkg::DATA_W-1:0] acc,
  input wire logic [exec_pkg::DATA_W-1:0] freg,
  output exec_pkg::alu_out_s res
);
  import exec_pkg::*;

  // Destination steering shared by every op that carries the d bit
  function automatic logic to_file(input logic dest);
    to_file = (dest == DEST_FILE);
  endfunction : to_file

  // Operation decode; sums wrap naturally at eight bits
  always_comb begin
    res = '0;
    case (instr.op)
      increment_register_op: begin
        res.result = freg + DATA_ONE;
        res.wr_file = to_file(instr.dest);
        res.wr_acc = !to_file(instr.dest);
        res.upd_zero = 1'b1;
      end
      increment_skip_zero_op: begin
        res.result = freg + DATA_ONE;
        res.wr_file = to_file(instr.dest);
        res.wr_acc = !to_file(instr.dest);
        res.skip = (res.result == DATA_ZERO);
        res.upd_zero = 1'b0; // Flags untouched
      end
      unconditional_branch_op: begin
        res.branch = 1'b1;
      end
      or_literal_op: begin
        res.result = acc | instr.literal[OR_LIT_MSB:0];
        res.wr_acc = 1'b1;
        res.upd_zero = 1'b1;
      end
      or_register_op: begin
        res.result = acc | freg;
        res.wr_file = to_file(instr.dest);
        res.wr_acc = !to_file(instr.dest);
        res.upd_zero = 1'b1;
      end
      store_accumulator_op: begin
        res.result = acc;
        res.wr_file = 1'b1;
      end
      register_move_op: begin
        res.result = freg;
        res.wr_file = to_file(instr.dest);
        res.wr_acc = !to_file(instr.dest);
        res.upd_zero = 1'b1; // Even on self write, acts as zero
      end
      default: begin
        res = '0;
      end
    endcase
    res.result_zero = (res.result == DATA_ZERO);
  end

endmodule : exec_alu
`default_nettype wire

// >>> rtl/file_regs.sv
// Thirty-two by eight file register array with one write and two read ports
`timescale 1ns/100ps
`default_nettype none
module file_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [exec_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [exec_pkg::DATA_W-1:0] wr_data,
  input wire logic [exec_pkg::ADDR_W-1:0] rd_addr,
  output logic [exec_pkg::DATA_W-1:0] rd_data,
  input wire logic [exec_pkg::ADDR_W-1:0] dbg_addr,
  output logic [exec_pkg::DATA_W-1:0] dbg_data_r
);
  import exec_pkg::*;

  logic [DATA_W-1:0] mem_r [FILE_DEPTH];

  // Storage; reset clears every location so reads are never unknown
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        mem_r[i] <= FILE_RESET;
      end
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Operand read is combinational so the op finishes in its own cycle
  assign rd_data = mem_r[rd_addr];

  // Observation port, registered so the top output comes from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      dbg_data_r <= FILE_RESET;
    end else begin
      dbg_data_r <= mem_r[dbg_addr];
    end
  end

endmodule : file_regs
`default_nettype wire

// >>> rtl/exec_core.sv
// Execution datapath top: accumulator, zero flag, file registers, skip and branch
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Destination bit 0 writes accumulator, 1 writes back the addressed file register.
// - Increment adds one to the file register, routes it, updates zero flag.
// - Increment-skip with zero result discards the fetched next instruction; two cycles.
// - Increment-skip writes its result but leaves every flag, zero included, untouched.
// - Branch loads nine-bit operand into target bits 8:0, page bits into 10:9.
// - Branch takes two cycles and accepts targets from zero to 511.
// - OR-literal combines accumulator with eight-bit literal into accumulator, updates zero.
// - OR-register combines accumulator with file register, routes result, updates zero.
// - Store copies accumulator into file register 0 to 31, flags unchanged.
// - Move copies file register to accumulator (d=0) or back to itself (d=1).
// - Move updates the zero flag even when writing the register back to itself.
module exec_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire exec_pkg::instr_s instr,
  input wire logic [exec_pkg::PAGE_W-1:0] page_bits,
  input wire logic [exec_pkg::ADDR_W-1:0] dbg_addr,
  output logic ready_r,
  output logic retire_r,
  output logic [exec_pkg::DATA_W-1:0] acc_r,
  output logic zero_r,
  output logic pc_load_r,
  output logic [exec_pkg::PC_W-1:0] pc_target_r,
  output logic discard_r,
  output logic file_wr_r,
  output logic [exec_pkg::ADDR_W-1:0] file_wr_addr_r,
  output logic [exec_pkg::DATA_W-1:0] file_wr_data_r,
  output logic [exec_pkg::DATA_W-1:0] dbg_data_r
);
  import exec_pkg::*;

  state_e state_r;
  state_e state_nxt;
  logic [1:0] extra_r;
  logic [1:0] extra_nxt;
  logic accept;
  logic [DATA_W-1:0] freg;
  alu_out_s res;
  logic file_we;

  // An instruction is taken only in the execute state
  assign accept = instr_valid && (state_r == st_exec);
  assign file_we = accept && res.wr_file;

  // Operand fetch and write-back share one array
  file_regs u_file_regs (
    .clk(clk),
    .reset(reset),
    .wr_en(file_we),
    .wr_addr(instr.addr),
    .wr_data(res.result),
    .rd_addr(instr.addr),
    .rd_data(freg),
    .dbg_addr(dbg_addr),
    .dbg_data_r(dbg_data_r)
  );

  // Result and flag decisions for the op on the issue port
  exec_alu u_exec_alu (
    .instr(instr),
    .acc(acc_r),
    .freg(freg),
    .res(res)
  );

  // Second-cycle sequencing: branch always, increment-skip only on zero
  always_comb begin
    state_nxt = state_r;
    extra_nxt = extra_r;
    case (state_r)
      st_exec: begin
        if (accept && res.branch) begin
          state_nxt = st_flush;
          extra_nxt = BRANCH_EXTRA;
        end else if (accept && res.skip) begin
          state_nxt = st_flush;
          extra_nxt = SKIP_EXTRA;
        end
      end
      st_flush: begin
        // The flushed slot behaves as a no-operation
        if (extra_r <= 2'h1) begin
          state_nxt = st_exec;
          extra_nxt = 2'h0;
        end else begin
          extra_nxt = extra_r - 2'h1;
        end
      end
      default: begin
        state_nxt = st_exec;
        extra_nxt = 2'h0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= st_exec;
      extra_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      extra_r <= extra_nxt;
    end
  end

  // Ready is registered from the next state, so it is low for the flush cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == st_exec);
    end
  end

  // Accumulator write-back
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_r <= ACC_RESET;
    end else if (accept && res.wr_acc) begin
      acc_r <= res.result;
    end
  end

  // Zero flag: only ops that affect it; store and skip leave it alone
  always_ff @(posedge clk) begin
    if (reset) begin
      zero_r <= ZERO_RESET;
    end else if (accept && res.upd_zero) begin
      zero_r <= res.result_zero;
    end
  end

  // Branch target: full nine-bit operand plus page bits, one-cycle load pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_load_r <= 1'b0;
      pc_target_r <= PC_RESET;
    end else begin
      pc_load_r <= accept && res.branch;
      if (accept && res.branch) begin
        pc_target_r <= {page_bits, instr.literal[PC_LOW_MSB:0]};
      end
    end
  end

  // Discard pulse tells fetch to drop the already fetched instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= accept && (res.skip || res.branch);
    end
  end

  // Mirror of the file write for observers; registered on the same edge that writes the array
  always_ff @(posedge clk) begin
    if (reset) begin
      file_wr_r <= 1'b0;
      file_wr_addr_r <= '0;
      file_wr_data_r <= DATA_ZERO;
    end else begin
      file_wr_r <= file_we;
      if (file_we) begin
        file_wr_addr_r <= instr.addr;
        file_wr_data_r <= res.result;
      end
    end
  end

  // Retire pulse: one per accepted instruction, no-operation included
  always_ff @(posedge clk) begin
    if (reset) begin
      retire_r <= 1'b0;
    end else begin
      retire_r <= accept;
    end
  end

endmodule : exec_core
`default_nettype wire

// >>> verif/exec_core_assertions.sv
// Concurrent checks on the execution datapath ports
`timescale 1ns/100ps
`default_nettype none
module exec_core_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire exec_pkg::instr_s instr,
  input wire logic [1:0] page_bits,
  input wire logic ready_r,
  input wire logic [7:0] acc_r,
  input wire logic zero_r,
  input wire logic pc_load_r,
  input wire logic [10:0] pc_target_r,
  input wire logic discard_r,
  input wire logic file_wr_r,
  input wire logic [4:0] file_wr_addr_r,
  input wire logic [7:0] file_wr_data_r
);
  import exec_pkg::*;
  // An issue is taken only while the block is ready
  wire logic tk = instr_valid && ready_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Branch accept, and the one dead slot that follows it
  sequence s_br; tk && instr.op == unconditional_branch_op; endsequence
  sequence s_gap; !ready_r ##1 ready_r; endsequence
  sequence s_skip; tk && instr.op == increment_skip_zero_op; endsequence
  a_branch_target: assert property (s_br |=> pc_load_r &&
    pc_target_r == {$past(page_bits), $past(instr.literal)}) else $error("bad branch target");
  a_branch_gap: assert property (s_br |=> s_gap) else $error("branch slot wrong");
  a_skip_gap: assert property (s_skip ##1 discard_r |-> s_gap) else $error("skip slot");
  a_discard_cause: assert property (discard_r |-> $past(tk)) else $error("stray discard");
  a_skip_flags: assert property (s_skip |=> $stable(zero_r)) else $error("skip moved zero");
  a_orlit_value: assert property (tk && instr.op == or_literal_op |=>
    acc_r == ($past(acc_r) | $past(instr.literal[7:0]))) else $error("bad or literal");
  a_store_write: assert property (tk && instr.op == store_accumulator_op |=> file_wr_r &&
    file_wr_data_r == $past(acc_r) && $stable(zero_r)) else $error("bad store");
  a_dest_file: assert property (tk && instr.dest == DEST_FILE && instr.op inside
    {increment_register_op, or_register_op, register_move_op} |=>
    file_wr_r && file_wr_addr_r == $past(instr.addr)) else $error("no file write");
  a_zero_result: assert property (tk && instr.dest == DEST_ACC && instr.op inside
    {increment_register_op, or_register_op, register_move_op} |=>
    zero_r == (acc_r == 8'h00)) else $error("zero flag wrong");
endmodule : exec_core_assertions
bind exec_core exec_core_assertions u_chk (.clk(clk), .reset(reset),
  .instr_valid(instr_valid), .instr(instr), .page_bits(page_bits), .ready_r(ready_r),
  .acc_r(acc_r), .zero_r(zero_r), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r),
  .discard_r(discard_r), .file_wr_r(file_wr_r), .file_wr_addr_r(file_wr_addr_r),
  .file_wr_data_r(file_wr_data_r));
`default_nettype wire

// >>> verif/test_increment_or_move_branch_exec.sv
// Self-checking bench for the execution datapath
`timescale 1ns/100ps
`default_nettype none
module test_increment_or_move_branch_exec;
  import exec_pkg::*;
  logic clk = 0, reset = 1, instr_valid = 0;
  instr_s instr = '0;
  logic [1:0] page_bits = 2'h0;
  logic [4:0] dbg_addr = 5'h0, file_wr_addr_r;
  logic ready_r, retire_r, zero_r, pc_load_r, discard_r, file_wr_r;
  logic [7:0] acc_r, file_wr_data_r, dbg_data_r;
  logic [10:0] pc_target_r;
  int n_mismatch = 0, samples_checked = 0;
  always #10 clk = ~clk;
  exec_core dut (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .page_bits(page_bits), .dbg_addr(dbg_addr), .ready_r(ready_r), .retire_r(retire_r),
    .acc_r(acc_r), .zero_r(zero_r), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r),
    .discard_r(discard_r), .file_wr_r(file_wr_r), .file_wr_addr_r(file_wr_addr_r),
    .file_wr_data_r(file_wr_data_r), .dbg_data_r(dbg_data_r));
  // Compare and count; unknowns never match
  task chk(logic [10:0] g, logic [10:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One issue at a falling edge, results settled at the next one
  task iss(op_e o, logic [4:0] a, logic d, logic [8:0] l);
    @(negedge clk);
    while (ready_r !== 1'b1) @(negedge clk);
    instr_valid = 1;
    instr = '{o, a, d, l};
    @(negedge clk);
    instr_valid = 0;
  endtask : iss
  // File content seen through the observe port, one cycle late
  task rd(logic [4:0] a, logic [7:0] e);
    dbg_addr = a;
    @(negedge clk);
    chk(dbg_data_r, e);
  endtask : rd
  // Register 31 is never written, so moving it clears the accumulator
  task lw(logic [7:0] v);
    iss(register_move_op, 5'h1f, DEST_ACC, 9'h0);
    iss(or_literal_op, 5'h0, DEST_ACC, {1'b0, v});
  endtask : lw
  task t_or_lit;
    lw(8'h00);
    chk(acc_r, 8'h00);
    chk(zero_r, 1'h1);
    iss(or_literal_op, 5'h0, DEST_ACC, 9'h1a5);
    chk(acc_r, 8'ha5);
    chk(zero_r, 1'h0);
  endtask : t_or_lit
  // Zero flag is raised first so a store that wrongly follows its value would clear it
  task t_inc;
    iss(register_move_op, 5'h6, DEST_FILE, 9'h0);
    iss(store_accumulator_op, 5'h2, DEST_FILE, 9'h0);
    chk(zero_r, 1'h1);
    rd(5'h2, 8'ha5);
    iss(increment_register_op, 5'h2, DEST_ACC, 9'h0);
    chk(acc_r, 8'ha6);
    rd(5'h2, 8'ha5);
    iss(increment_register_op, 5'h2, DEST_FILE, 9'h0);
    rd(5'h2, 8'ha6);
    lw(8'hff);
    iss(store_accumulator_op, 5'h3, DEST_FILE, 9'h0);
    iss(increment_register_op, 5'h3, DEST_ACC, 9'h0);
    chk(acc_r, 8'h00);
    chk(zero_r, 1'h1);
  endtask : t_inc
  // Wrap to zero skips; the zero flag must not follow the result
  task t_skip;
    iss(or_literal_op, 5'h0, DEST_ACC, 9'h002);
    iss(increment_skip_zero_op, 5'h3, DEST_FILE, 9'h0);
    chk(discard_r, 1'h1);
    chk(ready_r, 1'h0);
    chk(zero_r, 1'h0);
    rd(5'h3, 8'h00);
    iss(increment_skip_zero_op, 5'h3, DEST_ACC, 9'h0);
    chk(acc_r, 8'h01);
    chk({discard_r, ready_r}, 2'h1);
  endtask : t_skip
  task t_branch;
    static logic [8:0] l [3] = '{9'h1ff, 9'h000, 9'h0ab};
    static logic [1:0] p [3] = '{2'h2, 2'h3, 2'h1};
    for (int k = 0; k < 3; k++) begin
      page_bits = p[k];
      iss(unconditional_branch_op, 5'h0, DEST_ACC, l[k]);
      chk(pc_target_r, {p[k], l[k]});
      chk({pc_load_r, ready_r}, 2'h2);
    end
    // An increment held through the dead slot must land once only
    @(negedge clk);
    instr_valid = 1;
    instr = '{unconditional_branch_op, 5'h0, DEST_ACC, 9'h010};
    @(negedge clk);
    instr = '{increment_register_op, 5'h4, DEST_FILE, 9'h0};
    repeat (2) @(negedge clk);
    instr_valid = 0;
    rd(5'h4, 8'h01);
  endtask : t_branch
  task t_or_move;
    lw(8'h11);
    iss(or_register_op, 5'h2, DEST_ACC, 9'h0);
    chk(acc_r, 8'hb7);
    iss(or_register_op, 5'h5, DEST_FILE, 9'h0);
    rd(5'h5, 8'hb7);
    iss(register_move_op, 5'h6, DEST_FILE, 9'h0);
    chk(zero_r, 1'h1);
    iss(register_move_op, 5'h5, DEST_FILE, 9'h0);
    chk(zero_r, 1'h0);
    iss(register_move_op, 5'h2, DEST_ACC, 9'h0);
    chk(acc_r, 8'ha6);
  endtask : t_or_move
  // A no-operation retires once and leaves accumulator, flag and files alone
  task t_nop;
    iss(no_operation, 5'h5, DEST_FILE, 9'h0ff);
    chk({retire_r, file_wr_r, zero_r}, 3'h4);
    chk(acc_r, 8'ha6);
    @(negedge clk);
    chk(retire_r, 1'h0);
    rd(5'h5, 8'hb7);
  endtask : t_nop
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // Main sequence after a sixteen-cycle reset
  initial begin
    repeat (16) @(negedge clk);
    reset = 0;
    t_or_lit;
    t_inc;
    t_skip;
    t_branch;
    t_or_move;
    t_nop;
    test_done;
  end
  // Watchdog well past the eighty or so cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule : test_increment_or_move_branch_exec
`default_nettype wire
